// ### design/stack_pkg.sv
package stack_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          PC_W          = 23;
  localparam int          PC_LO_W       = 16;
  localparam int          PC_HI_W       = 7;
  localparam int          SRL_W         = 8;
  localparam int          RAM_AW        = 12;
  localparam logic [15:0] SP_RESET      = 16'h1000;
  localparam logic [15:0] SP_STEP       = 16'h0002;
  localparam logic [15:0] ALIGN_MASK    = 16'hfffe;

  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_PUSH     = 3'b001,
    OP_POP      = 3'b010,
    OP_CALL     = 3'b011,
    OP_EXC      = 3'b100,
    OP_RET      = 3'b101
  } stack_op_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ram_req_t;
endpackage

// ### design/stack_pointer_unit.sv
`timescale 1ns/1ps
// Behaviour
// R1: one working register is the pointer, auto-updated, also freely read and written.
// R2: pointer bit zero is always held at zero.
// R3: every reset loads the pointer with 0x1000.
// R4: pointer addresses first free word; stack grows upward.
// R5: pop decrements then reads; push writes then increments.
// R6: program counter low sixteen bits first, upper bits 22..16 next word.
// R7: call save fills upper part of second word with zeros.
// R8: exception save puts status low byte above upper counter bits.
// R9: pointer accesses never paged, stay within 0x0000..0xffff.
// R10: frame pointer likewise unpaged while frame pointer active is one.
// R11: software may reload pointer anywhere; stack spans both data spaces.
// R12: pointer steps by two per word pushed or popped.
module stack_pointer_unit (
  // clock and reset
  input  wire logic                              core_clk_i,
  input  wire logic                              sys_rst_i,
  // stack operation
  input  wire stack_pkg::stack_op_t              op_i,
  input  wire logic [stack_pkg::DATA_W-1:0]      push_data_i,
  input  wire logic [stack_pkg::PC_W-1:0]        program_counter_i,
  input  wire logic [stack_pkg::SRL_W-1:0]       status_low_byte_i,
  // ordinary register write
  input  wire logic                              sp_wr_i,
  input  wire logic [stack_pkg::DATA_W-1:0]      sp_wdata_i,
  // frame pointer
  input  wire logic                              frame_pointer_active_i,
  input  wire logic                              fp_paged_req_i,
  // results
  output logic [stack_pkg::DATA_W-1:0]           stack_pointer_reg_o,
  output logic                                   busy_o,
  output logic                                   pop_valid_o,
  output logic [stack_pkg::DATA_W-1:0]           pop_data_o,
  output logic [stack_pkg::PC_W-1:0]             ret_pc_o,
  output logic [stack_pkg::SRL_W-1:0]            ret_srl_o,
  output logic                                   ret_valid_o,
  output logic                                   fp_paging_en_o
);
  import stack_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SAVE2  = 3'b001,
    ST_POPW   = 3'b010,
    ST_RET1   = 3'b011,
    ST_RET2   = 3'b100,
    ST_RET3   = 3'b101
  } state_t;

  state_t             state_r, state_nxt;
  logic [DATA_W-1:0]  sp_r, sp_nxt;
  logic [DATA_W-1:0]  hi_word_r, hi_word_nxt;
  logic [DATA_W-1:0]  ret_hi_r, ret_hi_nxt;
  logic               busy_r, busy_nxt;
  logic               pop_valid_r, pop_valid_nxt;
  logic [DATA_W-1:0]  pop_data_r, pop_data_nxt;
  logic [PC_W-1:0]    ret_pc_r, ret_pc_nxt;
  logic [SRL_W-1:0]   ret_srl_r, ret_srl_nxt;
  logic               ret_valid_r, ret_valid_nxt;
  logic               fp_pg_r, fp_pg_nxt;
  ram_req_t           req;
  logic [DATA_W-1:0]  rdata;

  ////////////////////////////////////////////////////////////////////////////
  stack_ram u_ram (
    .core_clk_i (core_clk_i),
    .req_i      (req),
    .rdata_o    (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt     = state_r;
    sp_nxt        = sp_r;
    hi_word_nxt   = hi_word_r;
    ret_hi_nxt    = ret_hi_r;
    pop_valid_nxt = 1'b0;
    pop_data_nxt  = pop_data_r;
    ret_pc_nxt    = ret_pc_r;
    ret_srl_nxt   = ret_srl_r;
    ret_valid_nxt = 1'b0;
    req.we        = 1'b0;
    req.re        = 1'b0;
    // 16-bit address only, no paging [R9]
    req.addr      = sp_r;
    req.wdata     = '0;
    case (state_r)
      ST_IDLE: begin
        if (sp_wr_i) begin
          sp_nxt = sp_wdata_i & ALIGN_MASK; // [R1] [R2] [R11]
        end else begin
          case (op_i)
            OP_PUSH: begin
              req.we    = 1'b1; // [R5]
              req.wdata = push_data_i;
              sp_nxt    = sp_r + SP_STEP; // [R4] [R12]
            end
            OP_CALL: begin
              req.we      = 1'b1;
              req.wdata   = program_counter_i[PC_LO_W-1:0]; // [R6]
              sp_nxt      = sp_r + SP_STEP; // [R12]
              hi_word_nxt = {{(DATA_W-PC_HI_W){1'b0}},
                             program_counter_i[PC_W-1:PC_LO_W]}; // [R7]
              state_nxt   = ST_SAVE2;
            end
            OP_EXC: begin
              req.we      = 1'b1;
              req.wdata   = program_counter_i[PC_LO_W-1:0]; // [R6]
              sp_nxt      = sp_r + SP_STEP; // [R1]
              hi_word_nxt = {status_low_byte_i, 1'b0,
                             program_counter_i[PC_W-1:PC_LO_W]}; // [R8]
              state_nxt   = ST_SAVE2;
            end
            OP_POP: begin
              req.re    = 1'b1;
              req.addr  = sp_r - SP_STEP; // [R5]
              sp_nxt    = sp_r - SP_STEP; // [R12]
              state_nxt = ST_POPW;
            end
            OP_RET: begin
              req.re    = 1'b1;
              req.addr  = sp_r - SP_STEP; // [R5]
              sp_nxt    = sp_r - SP_STEP; // [R1]
              state_nxt = ST_RET1;
            end
            default: begin
            end
          endcase
        end
      end
      ST_SAVE2: begin
        req.we    = 1'b1;
        req.wdata = hi_word_r; // [R6]
        sp_nxt    = sp_r + SP_STEP; // [R12]
        state_nxt = ST_IDLE;
      end
      ST_POPW: begin
        pop_data_nxt  = rdata;
        pop_valid_nxt = 1'b1;
        state_nxt     = ST_IDLE;
      end
      ST_RET1: begin
        // high word stands only this cycle [R6]
        ret_hi_nxt = rdata;
        req.re     = 1'b1;
        req.addr   = sp_r - SP_STEP; // [R5]
        sp_nxt     = sp_r - SP_STEP; // [R12]
        state_nxt  = ST_RET2;
      end
      ST_RET2: begin
        state_nxt  = ST_RET3;
      end
      ST_RET3: begin
        ret_pc_nxt    = {ret_hi_r[PC_HI_W-1:0], rdata};
        ret_srl_nxt   = ret_hi_r[DATA_W-1:DATA_W-SRL_W];
        ret_valid_nxt = 1'b1;
        state_nxt     = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    sp_nxt   = sp_nxt & ALIGN_MASK; // [R2]
    busy_nxt = (state_nxt != ST_IDLE);
    // frame pointer paging gated off while active [R10]
    fp_pg_nxt = fp_paged_req_i & ~frame_pointer_active_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r     <= ST_IDLE;
      sp_r        <= SP_RESET; // [R3]
      hi_word_r   <= '0;
      ret_hi_r    <= '0;
      busy_r      <= 1'b0;
      pop_valid_r <= 1'b0;
      pop_data_r  <= '0;
      ret_pc_r    <= '0;
      ret_srl_r   <= '0;
      ret_valid_r <= 1'b0;
      fp_pg_r     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      sp_r        <= sp_nxt;
      hi_word_r   <= hi_word_nxt;
      ret_hi_r    <= ret_hi_nxt;
      busy_r      <= busy_nxt;
      pop_valid_r <= pop_valid_nxt;
      pop_data_r  <= pop_data_nxt;
      ret_pc_r    <= ret_pc_nxt;
      ret_srl_r   <= ret_srl_nxt;
      ret_valid_r <= ret_valid_nxt;
      fp_pg_r     <= fp_pg_nxt;
    end
  end

  assign stack_pointer_reg_o = sp_r;
  assign busy_o              = busy_r;
  assign pop_valid_o         = pop_valid_r;
  assign pop_data_o          = pop_data_r;
  assign ret_pc_o            = ret_pc_r;
  assign ret_srl_o           = ret_srl_r;
  assign ret_valid_o         = ret_valid_r;
  assign fp_paging_en_o      = fp_pg_r;
endmodule

// ### design/stack_ram.sv
`timescale 1ns/1ps
module stack_ram (
  // clock
  input  wire logic                             core_clk_i,
  // access
  input  wire stack_pkg::ram_req_t              req_i,
  output logic [stack_pkg::DATA_W-1:0]          rdata_o
);
  import stack_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];
  logic [DATA_W-1:0] rdata_r;
  logic [RAM_AW-1:0] widx;

  assign widx    = req_i.addr[RAM_AW:1];
  assign rdata_o = rdata_r;

  always_ff @(posedge core_clk_i) begin
    if (req_i.we) begin
      mem[widx] <= req_i.wdata;
    end
    if (req_i.re) begin
      rdata_r <= mem[widx];
    end
  end
endmodule

// ### sim/ram_shadow.sv
`timescale 1ns/1ps
module ram_shadow;
  logic [15:0] mem [0:4095];
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    mem[a[12:1]] = d;
  endtask
  function automatic logic [15:0] get(input logic [15:0] a);
    return mem[a[12:1]];
  endfunction
endmodule

// ### sim/stack_assertions.sv
`timescale 1ns/1ps
module stack_assertions import stack_pkg::*; (
  // watched ports
  input wire logic             core_clk_i,
  input wire logic             sys_rst_i,
  input wire stack_op_t        op_i,
  input wire logic             sp_wr_i,
  input wire logic [15:0]      sp_wdata_i,
  input wire logic             frame_pointer_active_i,
  input wire logic             fp_paged_req_i,
  input wire logic [15:0]      stack_pointer_reg_o,
  input wire logic             busy_o,
  input wire logic             pop_valid_o,
  input wire logic             ret_valid_o,
  input wire logic             fp_paging_en_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire take = !busy_o && !sp_wr_i;
  a_bit_zero:
    assert property (stack_pointer_reg_o[0] == 1'b0) else $error("pointer bit zero set");
  a_reset_value:
    assert property (disable iff (1'b0) sys_rst_i |=> stack_pointer_reg_o == 16'h1000) else $error("bad reset value");
  a_push_step:
    assert property (take && op_i == OP_PUSH |=> stack_pointer_reg_o == $past(stack_pointer_reg_o) + 16'h2)
      else $error("push step wrong");
  a_pop_step:
    assert property (take && op_i == OP_POP |=> stack_pointer_reg_o == $past(stack_pointer_reg_o) - 16'h2
      ##1 pop_valid_o) else $error("pop step wrong");
  a_save_frame:
    assert property (take && (op_i == OP_CALL || op_i == OP_EXC) |=> busy_o
      ##1 (!busy_o && stack_pointer_reg_o == $past(stack_pointer_reg_o, 2) + 16'h4)) else $error("save wrong");
  a_return_frame:
    assert property (take && op_i == OP_RET |=> ##3 (ret_valid_o
      && stack_pointer_reg_o == $past(stack_pointer_reg_o, 4) - 16'h4)) else $error("return wrong");
  a_plain_write:
    assert property (sp_wr_i && !busy_o |=> stack_pointer_reg_o == ($past(sp_wdata_i) & 16'hfffe))
      else $error("pointer write wrong");
  a_frame_paging:
    assert property (!$past(sys_rst_i) |-> fp_paging_en_o == ($past(fp_paged_req_i) && !$past(frame_pointer_active_i)))
      else $error("frame paging wrong");
endmodule
bind stack_pointer_unit stack_assertions chk (.core_clk_i, .sys_rst_i, .op_i, .sp_wr_i, .sp_wdata_i,
  .frame_pointer_active_i, .fp_paged_req_i, .stack_pointer_reg_o, .busy_o, .pop_valid_o, .ret_valid_o,
  .fp_paging_en_o);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import stack_pkg::*;
  logic core_clk_i, sys_rst_i, sp_wr_i, frame_pointer_active_i, fp_paged_req_i;
  stack_op_t op_i;
  logic [15:0] push_data_i, sp_wdata_i, stack_pointer_reg_o, pop_data_o;
  logic [22:0] program_counter_i, ret_pc_o;
  logic [7:0]  status_low_byte_i, ret_srl_o;
  logic        busy_o, pop_valid_o, ret_valid_o, fp_paging_en_o;
  int          num_errors = 0;
  int          samples_checked = 0;
  stack_pointer_unit uut (.core_clk_i, .sys_rst_i, .op_i, .push_data_i, .program_counter_i,
    .status_low_byte_i, .sp_wr_i, .sp_wdata_i, .frame_pointer_active_i, .fp_paged_req_i,
    .stack_pointer_reg_o, .busy_o, .pop_valid_o, .pop_data_o, .ret_pc_o, .ret_srl_o,
    .ret_valid_o, .fp_paging_en_o);
  ram_shadow shadow ();
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic step(input stack_op_t o);
    @(posedge core_clk_i);
    op_i <= o;
    @(posedge core_clk_i);
    op_i <= OP_NONE;
  endtask
  task automatic wait_for(input bit want_ret);
    for (int n = 0; n < 9; n++) begin
      @(posedge core_clk_i);
      #1;
      if (want_ret ? ret_valid_o === 1'b1 : busy_o === 1'b0) return;
    end
    num_errors++;
    tally_and_finish();
  endtask
  task automatic pop_chk(input logic [15:0] exp);
    step(OP_POP);
    @(posedge core_clk_i);
    #1;
    chk("pop valid", pop_valid_o, 1'b1);
    chk("pop data", pop_data_o, exp);
  endtask
  task automatic t_push_pop;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i);
      op_i <= OP_PUSH;
      push_data_i <= 16'ha5a0 + 16'(i);
      shadow.put(16'h1000 + 16'(2 * i), 16'ha5a0 + 16'(i));
    end
    @(posedge core_clk_i);
    op_i <= OP_NONE;
    #1;
    chk("sp after pushes", stack_pointer_reg_o, 16'h1006);
    for (int i = 2; i >= 0; i--) pop_chk(shadow.get(16'h1000 + 16'(2 * i)));
    chk("sp after pops", stack_pointer_reg_o, 16'h1000);
  endtask
  task automatic t_frames;
    step(OP_CALL);
    wait_for(1'b0);
    chk("sp after call", stack_pointer_reg_o, 16'h1004);
    pop_chk(16'h005a);
    pop_chk(16'h1234);
    step(OP_EXC);
    wait_for(1'b0);
    step(OP_RET);
    wait_for(1'b1);
    chk("return counter", ret_pc_o, 23'h5a1234);
    chk("return status", ret_srl_o, 8'hc3);
    chk("sp after return", stack_pointer_reg_o, 16'h1000);
  endtask
  task automatic t_write;
    @(posedge core_clk_i);
    sp_wr_i <= 1'b1;
    sp_wdata_i <= 16'h2345;
    @(posedge core_clk_i);
    sp_wdata_i <= 16'hfffe;
    #1;
    chk("odd write", stack_pointer_reg_o, 16'h2344);
    @(posedge core_clk_i);
    sp_wr_i <= 1'b0;
    op_i <= OP_PUSH;
    @(posedge core_clk_i);
    op_i <= OP_NONE;
    #1;
    chk("wrap at top", stack_pointer_reg_o, 16'h0000);
  endtask
  task automatic t_frame_paging;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      {frame_pointer_active_i, fp_paged_req_i} <= 2'(i);
      @(posedge core_clk_i);
      #1;
      chk("frame paging", fp_paging_en_o, 1'(i == 1));
    end
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    sys_rst_i = 1'b1;
    op_i = OP_NONE;
    {sp_wr_i, frame_pointer_active_i, fp_paged_req_i, push_data_i, sp_wdata_i} = '0;
    program_counter_i = 23'h5a1234;
    status_low_byte_i = 8'hc3;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("reset pointer", stack_pointer_reg_o, 16'h1000);
    t_push_pop();
    t_frames();
    t_write();
    t_frame_paging();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("second reset", stack_pointer_reg_o, 16'h1000);
    tally_and_finish();
  end
endmodule
